// ---- common/asc_pkg.sv ----
/*
  Constants for the conversion sequencer and start controller: register
  offsets, field positions, reset values and sequencing modes.
  Assumes a 200 MHz sequencer base clock and a byte-addressed register bus.
*/
package asc_pkg;

  localparam int unsigned BASE_CLK_HZ = 200_000_000;
  localparam int ADR_W = 8;
  localparam int FAF_W = 12;
  localparam int CNT_W = 16;

  localparam logic [7:0] OFS_RESET = 8'h00;
  localparam logic [7:0] OFS_DAC = 8'h04;
  localparam logic [7:0] OFS_BASE = 8'h0C;
  localparam logic [7:0] OFS_SDIV = 8'h10;
  localparam logic [7:0] OFS_CDIV = 8'h14;
  localparam logic [7:0] OFS_GLO = 8'h18;
  localparam logic [7:0] OFS_GHI = 8'h1C;
  localparam logic [7:0] OFS_FAF = 8'h20;
  localparam logic [7:0] OFS_FCNT = 8'h28;
  localparam logic [7:0] OFS_FDATA = 8'h30;
  localparam logic [7:0] OFS_CTRL0 = 8'h38;
  localparam logic [7:0] OFS_CTRL1 = 8'h3C;
  localparam logic [7:0] OFS_IRQ = 8'h40;
  localparam logic [7:0] OFS_DVAL = 8'h44;
  localparam logic [7:0] OFS_DCFG = 8'h48;
  localparam logic [7:0] OFS_REV = 8'h68;

  localparam logic [7:0] RESET_CMD = 8'hFF;

  // Converter control fields
  localparam int F_LAST_LSB = 0;
  localparam int F_GAIN_LSB = 4;
  localparam int F_MODE_LSB = 8;
  localparam int F_START = 16;
  localparam int F_SCAN = 18;
  // Interrupt register fields
  localparam int F_IRQ_FLAG = 0;
  localparam int F_IRQ_EN = 8;
  // Digital line configuration fields
  localparam int F_TRIG_EN = 0;
  localparam int F_XSTART_EN = 1;
  localparam int F_EDGE_FALL = 2;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    ASC_SEQ_SINGLE = 2'b00,
    ASC_SEQ_MODIFY = 2'b01,
    ASC_SEQ_ADV = 2'b10,
    ASC_SEQ_BASIC = 2'b11
  } asc_seq_t;

endpackage

// ---- verilog/asc_rate_div.sv ----
/*
  Programmable rate divider: one-cycle tick every div_i cycles.
  Assumes clr_i is held while the rate is not wanted; div_i of 0 or 1
  ticks every cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module asc_rate_div
  import asc_pkg::*;
#(
  parameter int W = 32
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic [W-1:0] div_i,
  output logic tick_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } asc_div_st_t;

  asc_div_st_t s_ff;
  asc_div_st_t nxt_s;

  // Refuse widths too narrow for the compare against div_i minus one
  if (W < 2)
  begin
    $error("asc_rate_div: W must be at least 2");
  end

  assign tick_o = !clr_i && ((div_i <= W'(1)) || (s_ff.cnt >= div_i - W'(1)));

  always_comb
  begin
    nxt_s = s_ff;
    if (clr_i || tick_o)
      nxt_s.cnt = '0;
    else
      nxt_s.cnt = s_ff.cnt + W'(1);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

endmodule
`default_nettype wire

// ---- verilog/asc_sequencer.sv ----
/*
  Conversion sequencer and start controller with a classic Wishbone slave.
  Drives start, channel and gain to two multiplexed converters; the sample
  FIFO itself lives outside and reports its fill count here.
  Assumes one 200 MHz clock; the trigger line is asynchronous.

*/
`timescale 1ns/1ps
`default_nettype none
module asc_sequencer
  import asc_pkg::*;
#(
  parameter logic [31:0] REV_CODE = 32'h0000_0001 // Arbitrary value
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic trig_line_i,
  input wire logic [CNT_W-1:0] fifo_count_i,
  input wire logic [31:0] fifo_data_i,
  output logic fifo_rd_o,
  output logic irq_o,
  output logic conv_start_o,
  output logic [2:0] conv_chan0_o,
  output logic [2:0] conv_chan1_o,
  output logic [2:0] conv_gain0_o,
  output logic [2:0] conv_gain1_o,
  output logic [31:0] dac_cmd_o,
  output logic dac_cmd_stb_o,
  output logic [1:0] dio_out_o,
  output logic board_rst_o
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] start_div;
    logic [31:0] scan_div;
    logic [31:0] gain_lo;
    logic [31:0] gain_hi;
    logic [FAF_W-1:0] faf;
    logic [31:0] ctrl0;
    logic [31:0] ctrl1;
    logic irq_en;
    logic irq_flag;
    logic [31:0] dac_cmd;
    logic dac_stb;
    logic [1:0] dio_val;
    logic [2:0] dio_cfg;
    logic [2:0] sync;
    logic line_st;
    logic running;
    logic armed;
    logic scanning;
    logic [2:0] chan;
    logic conv_stb;
    logic [2:0] conv_ch0;
    logic [2:0] conv_ch1;
    logic [2:0] conv_g0;
    logic [2:0] conv_g1;
    logic fifo_rd;
    logic brst;
  } asc_main_st_t;

  asc_main_st_t s_ff;
  asc_main_st_t nxt_s;

  logic start_tick;
  logic scan_tick;
  logic start_clr;
  logic scan_clr;

  logic bus_req;
  logic wr;
  logic full;
  logic edge_seen;
  logic ev;
  logic go0;
  logic go1;
  logic restart;
  logic conv;
  logic scan_eff;
  logic sdiv_nz;
  logic [31:0] cfg0;
  logic [31:0] cfg1;
  logic reached;
  logic [2:0] last;
  logic [2:0] ch;
  asc_seq_t mode0;
  asc_seq_t mode1;
  asc_seq_t wmode;

  // Periodic starts only count while running, so each run starts a full period
  assign start_clr = !s_ff.running;
  assign scan_clr = !s_ff.scanning;

  asc_rate_div #(
    .W(32)
  ) u_start_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(start_clr),
    .div_i(s_ff.start_div),
    .tick_o(start_tick)
  );

  asc_rate_div #(
    .W(32)
  ) u_scan_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(scan_clr),
    .div_i(s_ff.scan_div),
    .tick_o(scan_tick)
  );

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.ack = 1'b0;
    nxt_s.conv_stb = 1'b0;
    nxt_s.dac_stb = 1'b0;
    nxt_s.fifo_rd = 1'b0;
    nxt_s.brst = 1'b0;

    bus_req = wb_cyc_i && wb_stb_i && !s_ff.ack;
    wr = bus_req && wb_we_i;
    full = (wb_sel_i == 4'hF);
    wmode = asc_seq_t'(wb_dat_i[F_MODE_LSB +: 2]);
    // A go write must act on the settings it carries, not the old ones
    cfg0 = (wr && full && wb_adr_i == OFS_CTRL0) ? wb_dat_i : s_ff.ctrl0;
    cfg1 = (wr && full && wb_adr_i == OFS_CTRL1) ? wb_dat_i : s_ff.ctrl1;
    mode0 = asc_seq_t'(cfg0[F_MODE_LSB +: 2]);
    mode1 = asc_seq_t'(cfg1[F_MODE_LSB +: 2]);
    last = cfg0[F_LAST_LSB +: 3];
    sdiv_nz = (s_ff.start_div != RST_WORD);
    scan_eff = cfg0[F_SCAN] && (mode0 != ASC_SEQ_SINGLE)
      && (last != 3'h0);
    reached = (fifo_count_i >= {{(CNT_W-FAF_W){1'b0}}, s_ff.faf});

    // Trigger line: a level counts once the 2nd and 3rd stages agree
    nxt_s.sync = {s_ff.sync[1:0], trig_line_i};
    if (s_ff.sync[1] == s_ff.sync[2])
      nxt_s.line_st = s_ff.sync[2];
    edge_seen = (nxt_s.line_st != s_ff.line_st)
      && (nxt_s.line_st == !s_ff.dio_cfg[F_EDGE_FALL]);

    // Bus answer: one cycle after the request, zero on unmapped reads
    if (bus_req)
    begin
      nxt_s.ack = 1'b1;
      unique case (wb_adr_i)
        OFS_BASE: nxt_s.rdata = BASE_CLK_HZ;
        OFS_SDIV: nxt_s.rdata = s_ff.start_div;
        OFS_CDIV: nxt_s.rdata = s_ff.scan_div;
        OFS_GLO: nxt_s.rdata = s_ff.gain_lo;
        OFS_GHI: nxt_s.rdata = s_ff.gain_hi;
        OFS_FAF: nxt_s.rdata = {20'h0_0000, s_ff.faf};
        OFS_FCNT: nxt_s.rdata = {16'h0000, fifo_count_i};
        OFS_FDATA: nxt_s.rdata = fifo_data_i;
        OFS_CTRL0: nxt_s.rdata = s_ff.ctrl0;
        OFS_CTRL1: nxt_s.rdata = s_ff.ctrl1;
        OFS_IRQ: nxt_s.rdata = {23'h00_0000, s_ff.irq_en,
          7'h00, s_ff.irq_flag};
        OFS_DVAL: nxt_s.rdata = {30'h0000_0000, s_ff.dio_val};
        OFS_DCFG: nxt_s.rdata = {29'h0000_0000, s_ff.dio_cfg};
        OFS_REV: nxt_s.rdata = REV_CODE;
        default: nxt_s.rdata = RST_WORD;
      endcase
      if (wb_we_i)
        nxt_s.rdata = RST_WORD;
      // Popping on a read lets the FIFO present the next word afterwards
      if (!wb_we_i && wb_adr_i == OFS_FDATA)
        nxt_s.fifo_rd = 1'b1;
    end

    go0 = wr && full && (wb_adr_i == OFS_CTRL0) && wb_dat_i[F_START];
    go1 = wr && full && (wb_adr_i == OFS_CTRL1) && wb_dat_i[F_START];

    if (wr && full)
    begin
      unique case (wb_adr_i)
        OFS_DAC:
        begin
          nxt_s.dac_cmd = wb_dat_i;
          nxt_s.dac_stb = 1'b1;
        end
        OFS_SDIV: nxt_s.start_div = wb_dat_i;
        OFS_CDIV: nxt_s.scan_div = wb_dat_i;
        OFS_GLO: nxt_s.gain_lo = wb_dat_i;
        OFS_GHI: nxt_s.gain_hi = wb_dat_i;
        OFS_FAF: nxt_s.faf = wb_dat_i[FAF_W-1:0];
        OFS_CTRL0: nxt_s.ctrl0 = wb_dat_i;
        OFS_CTRL1: nxt_s.ctrl1 = wb_dat_i;
        OFS_IRQ:
        begin
          if (wb_dat_i[F_IRQ_FLAG])
            nxt_s.irq_flag = 1'b0;
          nxt_s.irq_en = wb_dat_i[F_IRQ_EN];
        end
        OFS_DVAL: nxt_s.dio_val = wb_dat_i[1:0];
        OFS_DCFG: nxt_s.dio_cfg = wb_dat_i[2:0];
        default: nxt_s.rdata = nxt_s.rdata;
      endcase
    end

    // A flag raised in the clearing cycle survives
    if (reached)
      nxt_s.irq_flag = 1'b1;

    // Start sources
    ev = 1'b0;
    if ((go0 || go1) && !sdiv_nz)
      ev = 1'b1;
    if (go0 && sdiv_nz)
    begin
      if (s_ff.dio_cfg[F_TRIG_EN])
      begin
        nxt_s.armed = 1'b1;
        nxt_s.running = 1'b0;
      end
      else
      begin
        nxt_s.running = 1'b1;
        nxt_s.armed = 1'b0;
        ev = 1'b1;
      end
    end
    if (wr && full && wb_adr_i == OFS_CTRL0 && !wb_dat_i[F_START])
    begin
      nxt_s.running = 1'b0;
      nxt_s.armed = 1'b0;
    end
    if (s_ff.armed && edge_seen && s_ff.dio_cfg[F_TRIG_EN] && sdiv_nz)
    begin
      nxt_s.armed = 1'b0;
      nxt_s.running = 1'b1;
      ev = 1'b1;
    end
    if (s_ff.running && start_tick)
      ev = 1'b1;
    if (s_ff.dio_cfg[F_XSTART_EN] && edge_seen)
      ev = 1'b1;

    // Mode 01 leaves the walk where it is so settings can change mid-run
    restart = (go0 || go1) && (wmode != ASC_SEQ_MODIFY);
    if (restart)
      nxt_s.scanning = 1'b0;
    ch = restart ? 3'h0 : s_ff.chan;

    conv = 1'b0;
    if (s_ff.scanning && !restart)
    begin
      conv = scan_tick;
    end
    else if (ev)
    begin
      conv = 1'b1;
      if (scan_eff)
      begin
        nxt_s.scanning = 1'b1;
        ch = 3'h0;
      end
    end

    nxt_s.chan = ch;
    if (conv)
    begin
      nxt_s.conv_stb = 1'b1;
      if (ch >= last)
      begin
        nxt_s.chan = 3'h0;
        nxt_s.scanning = 1'b0;
      end
      else
        nxt_s.chan = ch + 3'h1;
      // Mode 00 pins the channel to the selected one
      nxt_s.conv_ch0 = (mode0 == ASC_SEQ_SINGLE) ? last : ch;
      nxt_s.conv_ch1 = (mode1 == ASC_SEQ_SINGLE)
        ? cfg1[F_LAST_LSB +: 3] : ch;
      nxt_s.conv_g0 = (mode0 == ASC_SEQ_ADV)
        ? s_ff.gain_lo[{ch, 2'b00} +: 3]
        : cfg0[F_GAIN_LSB +: 3];
      nxt_s.conv_g1 = (mode1 == ASC_SEQ_ADV)
        ? s_ff.gain_hi[{ch, 2'b00} +: 3]
        : cfg1[F_GAIN_LSB +: 3];
    end

    // Board reset: every register but the trigger synchroniser back to power-up, the answer still given
    if (wr && wb_sel_i[0] && wb_adr_i == OFS_RESET
      && wb_dat_i[7:0] == RESET_CMD)
    begin
      nxt_s = '0;
      nxt_s.ack = 1'b1;
      nxt_s.brst = 1'b1;
      nxt_s.sync = {s_ff.sync[1:0], trig_line_i};
      nxt_s.line_st = s_ff.line_st;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign wb_ack_o = s_ff.ack;
  assign wb_dat_o = s_ff.rdata;
  assign fifo_rd_o = s_ff.fifo_rd;
  assign irq_o = s_ff.irq_flag && s_ff.irq_en;
  assign conv_start_o = s_ff.conv_stb;
  assign conv_chan0_o = s_ff.conv_ch0;
  assign conv_chan1_o = s_ff.conv_ch1;
  assign conv_gain0_o = s_ff.conv_g0;
  assign conv_gain1_o = s_ff.conv_g1;
  assign dac_cmd_o = s_ff.dac_cmd;
  assign dac_cmd_stb_o = s_ff.dac_stb;
  assign dio_out_o = s_ff.dio_val;
  assign board_rst_o = s_ff.brst;

endmodule
`default_nettype wire

// ---- testbench/asc_seq_asserts.sv ----
/* Port checker for the sequencer.
   Bound to every asc_sequencer; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module asc_seq_asserts
  import asc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic fifo_rd_o,
  input wire logic irq_o,
  input wire logic conv_start_o,
  input wire logic [2:0] conv_chan0_o,
  input wire logic [2:0] conv_gain0_o,
  input wire logic board_rst_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic rst_req_ff;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_req_ff <= 1'b0;
    else
      rst_req_ff <= wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
        && wb_adr_i == OFS_RESET && wb_dat_i[7:0] == RESET_CMD;
  end
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_go;
    s_take ##0 (wb_we_i && wb_adr_i == OFS_CTRL0 && wb_sel_i == 4'hF
      && wb_dat_i[F_START] && wb_dat_i[9:8] != 2'b01
      && wb_dat_i[9:8] != 2'b00);
  endsequence
  property p_ack_one;
    s_take |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  property p_base;
    s_take ##0 (!wb_we_i && wb_adr_i == OFS_BASE) |=>
      wb_dat_o == BASE_CLK_HZ;
  endproperty
  property p_fifo_rd;
    fifo_rd_o |-> wb_ack_o && $past(wb_adr_i) == OFS_FDATA;
  endproperty
  property p_wr_zero;
    wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0000_0000;
  endproperty
  property p_go_ch0;
    s_go |=> (conv_start_o |-> conv_chan0_o == 3'h0);
  endproperty
  // Channel and gain must not drift between starts
  property p_hold;
    !conv_start_o && !board_rst_o && !$past(board_rst_o) |->
      $stable(conv_chan0_o) && $stable(conv_gain0_o);
  endproperty
  property p_rst_cmd;
    board_rst_o |-> rst_req_ff;
  endproperty
  property p_rst_clear;
    board_rst_o |=> ##1 (!irq_o && conv_chan0_o == 3'h0);
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack is not a one-cycle answer");
  a_base: assert property (p_base)
    else $error("base clock read wrong");
  a_fifo_rd: assert property (p_fifo_rd)
    else $error("fifo read pulse without data read");
  a_wr_zero: assert property (p_wr_zero)
    else $error("write answer carries data");
  a_go_ch0: assert property (p_go_ch0)
    else $error("go did not restart at channel zero");
  a_hold: assert property (p_hold)
    else $error("channel or gain moved without start");
  a_rst_cmd: assert property (p_rst_cmd)
    else $error("board reset without command");
  a_rst_clear: assert property (p_rst_clear)
    else $error("board reset left state behind");
endmodule
bind asc_sequencer asc_seq_asserts u_chk (.clk_i, .rst_n_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .fifo_rd_o, .irq_o, .conv_start_o, .conv_chan0_o,
  .conv_gain0_o, .board_rst_o);
`default_nettype wire

// ---- testbench/asc_conv_model.sv ----
/* Behavioural model of converter 0 (channel 0 and gain 0 only) and its result FIFO.
   Runs on the sequencer clock; logs each start as channel and gain. */
`timescale 1ns/1ps
`default_nettype none
module asc_conv_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [2:0] chan_i,
  input wire logic [2:0] gain_i,
  input wire logic rd_i,
  output logic [15:0] count_o,
  output logic [31:0] data_o
);
  int n_starts = 0;
  int gap = 0;
  int since = 0;
  logic [5:0] log_q[$];
  // Head word flips on every read so a stale value never passes
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count_o <= 16'h0000;
      data_o <= 32'h5A5A_5A5A;
    end
    else
    begin
      count_o <= count_o + 16'(start_i) - 16'(rd_i && count_o != 0);
      if (rd_i)
        data_o <= ~data_o;
    end
  end
  always @(posedge clk_i)
  begin
    since++;
    if (start_i === 1'b1)
    begin
      log_q.push_back({chan_i, gain_i});
      n_starts++;
      gap = since;
      since = 0;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
/* Self-checking bench for the sequencer.
   Drives the register bus and trigger line; converter model on far side. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import asc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic trig = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, dat_o, fdat;
  logic [15:0] fcnt;
  logic ack, frd, irq, start, brst, dac_stb;
  logic [2:0] ch0, gn0, ch1, gn1;
  logic [31:0] dac;
  logic [1:0] digital_line;
  int n_dac = 0;
  int err_total = 0;
  int n_compared = 0;
  int cyc_n = 0;
  asc_sequencer DUT (.clk_i, .rst_n_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .trig_line_i(trig),
    .fifo_count_i(fcnt), .fifo_data_i(fdat), .fifo_rd_o(frd),
    .irq_o(irq), .conv_start_o(start), .conv_chan0_o(ch0),
    .conv_chan1_o(ch1), .conv_gain0_o(gn0), .conv_gain1_o(gn1),
    .dac_cmd_o(dac), .dac_cmd_stb_o(dac_stb), .dio_out_o(digital_line),
    .board_rst_o(brst));
  asc_conv_model u_conv (.clk_i, .rst_n_i, .start_i(start), .chan_i(ch0),
    .gain_i(gn0), .rd_i(frd), .count_o(fcnt), .data_o(fdat));
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (dac_stb === 1'b1)
      n_dac++;
    if (cyc_n == 5000)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: run hung", $time);
      report_and_stop();
    end
  end
  task report_and_stop();
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Stb rides with cyc; request held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    rdat = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask
  task rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0000_0000, 4'hF);
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task t_regs();
    rd(OFS_BASE);
    cmp(rdat, BASE_CLK_HZ);
    rd(8'h08);
    cmp(rdat, 32'h0000_0000);
    wr(OFS_FAF, 32'hFFFF_FFFF);
    rd(OFS_FAF);
    cmp(rdat, 32'h0000_0FFF);
    wr(OFS_DAC, 32'h0012_3456);
    cmp(dac, 32'h0012_3456);
    wr(OFS_DVAL, 32'h0000_0003);
    cmp({30'h0, digital_line}, 32'h0000_0003);
    cmp(n_dac, 1);
  endtask
  task t_scan();
    wr(OFS_CDIV, 32'h0000_0003);
    wr(OFS_GLO, 32'h0000_0321);
    wr(OFS_GHI, 32'h0000_0754);
    wr(OFS_CTRL1, 32'h0000_0200);
    u_conv.log_q.delete();
    wr(OFS_CTRL0, 32'h0005_0202);
    tick(20);
    cmp(u_conv.log_q.size(), 3);
    cmp({u_conv.log_q[0], u_conv.log_q[1], u_conv.log_q[2]},
      {6'o01, 6'o12, 6'o23});
    cmp(u_conv.gap, 3);
    cmp({ch1, gn1}, 6'o27);
  endtask
  task t_walk();
    u_conv.log_q.delete();
    wr(OFS_CTRL0, 32'h0001_0352);
    repeat (3) wr(OFS_CTRL0, 32'h0001_0152);
    tick(4);
    cmp(u_conv.log_q.size(), 4);
    cmp({u_conv.log_q[0], u_conv.log_q[1], u_conv.log_q[2],
      u_conv.log_q[3]}, {6'o05, 6'o15, 6'o25, 6'o05});
    // Scan bit with mode 00 and last 3 must still give one start
    u_conv.log_q.delete();
    wr(OFS_CTRL0, 32'h0005_0003);
    tick(20);
    cmp(u_conv.log_q.size(), 1);
    cmp(u_conv.log_q[0], 6'o30);
  endtask
  task t_period();
    int n;
    wr(OFS_SDIV, 32'h0000_000A);
    wr(OFS_CTRL1, 32'h0000_0000);
    wr(OFS_CTRL0, 32'h0001_0023);
    tick(40);
    cmp(u_conv.gap, 10);
    cmp(u_conv.log_q[$], 6'o32);
    wr(OFS_CTRL0, 32'h0000_0023);
    tick(2);
    n = u_conv.n_starts;
    tick(30);
    cmp(u_conv.n_starts, n);
    wr(OFS_DCFG, 32'h0000_0001);
    wr(OFS_CTRL0, 32'h0001_0023);
    tick(30);
    cmp(u_conv.n_starts, n);
    trig <= 1'b1;
    tick(10);
    cmp(u_conv.n_starts > n, 1);
    wr(OFS_CTRL0, 32'h0000_0023);
    wr(OFS_SDIV, 32'h0000_0000);
    trig <= 1'b0;
    wr(OFS_DCFG, 32'h0000_0002);
    n = u_conv.n_starts;
    trig <= 1'b1;
    tick(10);
    cmp(u_conv.n_starts, n + 1);
    trig <= 1'b0;
    tick(10);
    cmp(u_conv.n_starts, n + 1);
  endtask
  task t_irq();
    // The flag has been latched since reset; clear it with the enable bit set
    wr(OFS_IRQ, 32'h0000_0101);
    tick(3);
    cmp(irq, 1'b0);
    wr(OFS_FAF, 32'h0000_0001);
    tick(3);
    cmp(irq, 1'b1);
    rd(OFS_IRQ);
    cmp(rdat, 32'h0000_0101);
    // Clear while the level is still reached: the set must win
    wr(OFS_IRQ, 32'h0000_0101);
    cmp(irq, 1'b1);
    wr(OFS_FAF, 32'h0000_0FFF);
    wr(OFS_IRQ, 32'h0000_0101);
    tick(3);
    cmp(irq, 1'b0);
    rd(OFS_FCNT);
    cmp(rdat, {16'h0000, u_conv.count_o});
    rd(OFS_FDATA);
    cmp(rdat, 32'h5A5A_5A5A);
    rd(OFS_FDATA);
    cmp(rdat, 32'hA5A5_A5A5);
  endtask
  task t_reset();
    wb(1'b1, OFS_RESET, 32'h0000_00FF, 4'h1);
    tick(3);
    rd(OFS_FAF);
    cmp(rdat, 32'h0000_0000);
    rd(OFS_CTRL0);
    cmp(rdat, 32'h0000_0000);
    cmp({30'h0, digital_line}, 32'h0000_0000);
  endtask
  initial
  begin
    tick(16);
    rst_n_i <= 1'b1;
    t_regs();
    t_scan();
    t_walk();
    t_period();
    t_irq();
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
